// ===== acdr_consts.svh
// Constants for the converter clock divider and reset block
`ifndef ACDR_CONSTS_SVH
`define ACDR_CONSTS_SVH
`define ACDR_PRE_DEFAULT   2'h0
`define ACDR_OSR_DEFAULT   3'h3
`define ACDR_EXT_DEFAULT   1'h0
`define ACDR_SAMPLE_DIV    4
`define ACDR_OSR_MIN_LOG2  5
`define ACDR_OSR_MAX_LOG2  12
`define ACDR_PRE_MAX_LOG2  3
`define ACDR_CNT_W         16
`endif

// ===== acdr_pkg.sv
// Types for the converter clock divider and reset block
package acdr_pkg;
  typedef struct packed {
    logic [1:0] prescale_sel;
    logic [2:0] oversample_sel;
    logic       ext_clock_sel;
  } acdr_cfg_s;

  typedef struct packed {
    logic analog_tick;
    logic sample_tick;
    logic rate_tick;
  } acdr_ticks_s;
endpackage

// ===== acdr_prescaler.sv
// Master clock prescaler producing the analog clock enable
`timescale 1ns/1ps
`default_nettype none
`include "acdr_consts.svh"
module acdr_prescaler (
  input  wire logic       clk,      // Master clock
  input  wire logic       run,      // High when counting is allowed
  input  wire logic [1:0] sel,      // Prescale code
  output logic            tick      // One-cycle analog clock enable
);
  typedef struct packed {
    logic [`ACDR_PRE_MAX_LOG2-1:0] cnt;
  } acdr_pre_state_s;

  acdr_pre_state_s st_reg;
  acdr_pre_state_s st_next;
  logic [`ACDR_PRE_MAX_LOG2-1:0] last;

  always_comb begin
    last    = 3'((1 << sel) - 1);
    st_next = st_reg;
    if (!run) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= last) begin
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 3'h1;
    end
  end

  assign tick = run && (st_reg.cnt >= last);

  always_ff @(posedge clk) begin
    st_reg <= st_next;
  end
endmodule // acdr_prescaler
`default_nettype wire

// ===== acdr_top.sv
// Converter clock divider and master reset control
// What this block does
// - An active-low master reset holds the block in its reset state, except the select and clock pin samplers and the master clock level.
// - Reset forces all configuration to its default values.
// - While reset is low all serial traffic is ignored whatever the select level.
// - During reset internal clock enables stay off except the input sampling path.
// - The reset state equals the power-on state.
// - With the master clock running, conversion starts right on reset release.
// - The external-clock select picks the external input when 1, else the oscillator.
// - The analog clock is master clock divided by 1, 2, 4 or 8 per the prescale code.
// - The sampling clock is the analog clock divided by four.
// - Each sampling clock period gives exactly one modulator sample.
// - The output rate clock is the sampling clock divided by the ratio 32 to 4096.
// - One data-ready pulse marks each new result, at the output rate.
// - The three-bit ratio code selects 32 times two to the code, default code 3.
// - Each data-ready pulse is low for half a sampling period, on the master clock.
`timescale 1ns/1ps
`default_nettype none
`include "acdr_consts.svh"
module acdr_top #(
  parameter int CNT_W = `ACDR_CNT_W
) (
  input  wire logic       REF_CLK,          // Block clock, master clock domain
  input  wire logic       RST_N,            // Master reset, active low
  input  wire logic       OSC_IN_PIN,       // Oscillator master clock level
  input  wire logic       EXT_CLK_IN,       // External clock input level
  input  wire logic       EXT_CLOCK_SEL,    // 1 selects external clock input
  input  wire logic [1:0] PRESCALE_SEL,     // Prescale code
  input  wire logic [2:0] OVERSAMPLE_SEL,   // Oversampling code
  input  wire logic       CFG_LOAD,         // Load configuration pulse
  input  wire logic       SERIAL_SEL_N,     // Serial chip select, active low
  output logic            MASTER_CLK_OUT,   // Selected master clock level
  output logic            SERIAL_EN,        // Serial port enabled
  output logic            INPUT_CLK_EN,     // Input sampling path enable
  output logic            CORE_CLK_EN,      // Internal logic clock enable
  output logic            ANALOG_CLOCK,     // Analog clock enable pulse
  output logic            SAMPLING_CLOCK,   // Sampling clock enable pulse
  output logic            OUTPUT_RATE_CLOCK,// Output rate pulse
  output logic            SAMPLE_STROBE,    // One modulator sample per period
  output logic            RESULT_READY_N    // Data-ready, active low
);
  // Counters must hold the largest ratio
  if (CNT_W < `ACDR_OSR_MAX_LOG2 + 1) begin : g_cnt_w_check
    $error("CNT_W too small for the largest oversampling ratio");
  end

  // Ratio shifts are worked in 32 bits
  if (CNT_W > 32) begin : g_cnt_w_limit
    $error("CNT_W wider than the ratio arithmetic allows");
  end

  // The sampling divider is a two-bit wrap counter
  if (`ACDR_SAMPLE_DIV != 4) begin : g_div_check
    $error("sampling divider must stay at four");
  end

  // Whole state in one word; the select and clock pin samplers sit beside the
  // counters but keep running through reset
  typedef struct packed {
    // Configuration latched by CFG_LOAD
    acdr_pkg::acdr_cfg_s cfg;
    // Pin samplers, two stages each
    logic [1:0]          sync_rst;
    logic [1:0]          sync_sel;
    logic [1:0]          sync_osc;
    logic [1:0]          sync_ext;
    // Divide chain counters
    logic [1:0]          div4;
    logic [CNT_W-1:0]    osr_cnt;
    // Data-ready timer
    logic [CNT_W-1:0]    ready_cnt;
    logic                ready_low;
    // Registered level and output pulses
    logic                mclk;
    logic                rate_p;
    logic                samp_p;
  } acdr_state_s;

  // Last count of the sampling divider
  localparam logic [1:0] DIV4_LAST = 2'(`ACDR_SAMPLE_DIV - 1);

  acdr_state_s st_reg;
  acdr_state_s st_next;
  logic        run;
  logic        pre_tick;
  logic        samp_tick;
  logic        rate_tick;
  logic [CNT_W-1:0] half_len;

  function automatic logic [CNT_W-1:0] osr_ratio(input logic [2:0] code);
    osr_ratio = CNT_W'(1) << (`ACDR_OSR_MIN_LOG2 + 32'(code));
  endfunction

  function automatic logic [CNT_W-1:0] pre_ratio(input logic [1:0] code);
    pre_ratio = CNT_W'(1) << code;
  endfunction

  // Last sampling count of a result period
  // for a ratio code
  function automatic logic [CNT_W-1:0] rate_last(input logic [2:0] code);
    rate_last = osr_ratio(code) - CNT_W'(1);
  endfunction

  // Data-ready low time: half a sampling period
  // counted in master clocks
  function automatic logic [CNT_W-1:0] ready_len(input logic [1:0] code);
    ready_len = CNT_W'((pre_ratio(code) * `ACDR_SAMPLE_DIV) >> 1);
  endfunction

  // Two-stage pin sampler: new level enters the first stage
  // and only the second stage is read by logic
  function automatic logic [1:0] shift_in(input logic [1:0] stages, input logic level);
    shift_in = {stages[0], level};
  endfunction

  // Power-on state: all but the select and clock pin samplers
  // and the master clock level returns to defaults; held reset
  // gives the same word as a fresh start
  function automatic acdr_state_s reset_state(input acdr_state_s cur);
    reset_state                    = cur;
    reset_state.cfg.prescale_sel   = `ACDR_PRE_DEFAULT;
    reset_state.cfg.oversample_sel = `ACDR_OSR_DEFAULT;
    reset_state.cfg.ext_clock_sel  = `ACDR_EXT_DEFAULT;
    reset_state.div4               = '0;
    reset_state.osr_cnt            = '0;
    reset_state.ready_cnt          = '0;
    reset_state.ready_low          = 1'b0;
    reset_state.sync_rst           = '0;
    reset_state.samp_p             = 1'b0;
    reset_state.rate_p             = 1'b0;
  endfunction

  assign run = RST_N;

  // Prescaler runs only out of reset; its count clears while held
  acdr_prescaler u_pre (
    .clk  (REF_CLK),
    .run  (run),
    .sel  (st_reg.cfg.prescale_sel),
    .tick (pre_tick)
  );

  // Half a sampling period in master clocks: 4 x prescale / 2
  assign half_len  = ready_len(st_reg.cfg.prescale_sel);
  // Fourth prescaler tick ends a sampling period
  assign samp_tick = run && pre_tick && (st_reg.div4 == DIV4_LAST);
  // Reached or passed: a smaller ratio loaded mid-period ends
  // the period at the next sampling tick instead of running through the range
  assign rate_tick = samp_tick &&
                     (st_reg.osr_cnt >= rate_last(st_reg.cfg.oversample_sel));

  // Divide chain, all on the master clock as enables:
  //   prescaler tick every 1, 2, 4 or 8 clocks
  //   sampling tick on every fourth prescaler tick
  //   rate tick on the last sampling tick of a ratio
  // All but the prescaler tick are registered once before they leave, so the sampling
  // and rate outputs trail the internal enables by one clock.
  // Reset clears every counter, so the first result after release
  // lands one whole result period later, as after power-on.
  always_comb begin
    st_next          = st_reg;
    st_next.sync_rst = shift_in(st_reg.sync_rst, 1'b1);
    st_next.sync_sel = shift_in(st_reg.sync_sel, SERIAL_SEL_N);
    st_next.sync_osc = shift_in(st_reg.sync_osc, OSC_IN_PIN);
    st_next.sync_ext = shift_in(st_reg.sync_ext, EXT_CLK_IN);
    // Ticks registered once before they leave
    st_next.samp_p   = samp_tick;
    st_next.rate_p   = rate_tick;
    // Clock source mux, selected level
    st_next.mclk = st_reg.cfg.ext_clock_sel ? st_reg.sync_ext[1] : st_reg.sync_osc[1];
    if (!run) begin
      // Select and clock pin samplers and the clock level above keep running; all else to power-on values
      st_next = reset_state(st_next);
    end else begin
      // Configuration is taken only out of reset
      if (CFG_LOAD) begin
        st_next.cfg.prescale_sel   = PRESCALE_SEL;
        st_next.cfg.oversample_sel = OVERSAMPLE_SEL;
        st_next.cfg.ext_clock_sel  = EXT_CLOCK_SEL;
      end
      // Sampling divider
      if (pre_tick) begin
        st_next.div4 = st_reg.div4 + 2'h1;
      end
      // Ratio counter
      if (rate_tick) begin
        st_next.osr_cnt = '0;
      end else if (samp_tick) begin
        st_next.osr_cnt = st_reg.osr_cnt + CNT_W'(1);
      end
      // Data-ready timer
      if (rate_tick) begin
        st_next.ready_low = 1'b1;
        st_next.ready_cnt = half_len - CNT_W'(1);
      end else if (st_reg.ready_low) begin
        if (st_reg.ready_cnt == '0) begin
          st_next.ready_low = 1'b0;
        end else begin
          st_next.ready_cnt = st_reg.ready_cnt - CNT_W'(1);
        end
      end
    end
  end

  // One register stage for the whole state; reset acts through run
  always_ff @(posedge REF_CLK) begin
    st_reg <= st_next;
  end

  // Output timing seen from the pins:
  //   analog clock is combinational and runs in the release cycle
  //   core and serial enables wait two clocks for the reset stages
  //   the input path enable never drops, the select and clock pin samplers run in reset
  //   data-ready falls with the rate pulse and stays low half a period
  //   master clock level trails its pin by three clocks
  assign MASTER_CLK_OUT    = st_reg.mclk;
  assign INPUT_CLK_EN      = 1'b1;
  assign CORE_CLK_EN       = st_reg.sync_rst[1];
  assign SERIAL_EN         = st_reg.sync_rst[1] && !st_reg.sync_sel[1];
  assign ANALOG_CLOCK      = pre_tick;
  assign SAMPLING_CLOCK    = st_reg.samp_p;
  assign SAMPLE_STROBE     = st_reg.samp_p;
  assign OUTPUT_RATE_CLOCK = st_reg.rate_p;
  assign RESULT_READY_N    = !st_reg.ready_low;
endmodule // acdr_top
`default_nettype wire

// ===== acdr_monitor.sv
// Port assertions for the converter clock divider and reset block
`timescale 1ns/1ps
`default_nettype none
module acdr_monitor (
  input wire logic REF_CLK,           // Master clock
  input wire logic RST_N,             // Master reset
  input wire logic SERIAL_EN,         // Serial enable
  input wire logic INPUT_CLK_EN,      // Input path enable
  input wire logic CORE_CLK_EN,       // Core enable
  input wire logic ANALOG_CLOCK,      // Analog tick
  input wire logic SAMPLING_CLOCK,    // Sampling tick
  input wire logic OUTPUT_RATE_CLOCK, // Rate tick
  input wire logic SAMPLE_STROBE,     // Sample strobe
  input wire logic RESULT_READY_N     // Data-ready
);
  default clocking cb @(posedge REF_CLK); endclocking
  sequence s_held; !RST_N ##1 !RST_N; endsequence
  sequence s_release; !RST_N ##1 RST_N; endsequence
  AST_RST_HOLD: assert property (s_held |-> RESULT_READY_N && !SAMPLING_CLOCK && !ANALOG_CLOCK && !OUTPUT_RATE_CLOCK)
    else $error("outputs active in reset");
  AST_SER_BLOCK: assert property (s_held |-> !SERIAL_EN)
    else $error("serial enabled in reset");
  AST_CORE_GATE: assert property (s_held |-> !CORE_CLK_EN && INPUT_CLK_EN)
    else $error("clock enables wrong in reset");
  AST_CORE_RUN: assert property (s_release |-> ##[1:4] CORE_CLK_EN)
    else $error("core not running after release");
  AST_STROBE: assert property (disable iff (!RST_N) SAMPLE_STROBE == SAMPLING_CLOCK)
    else $error("strobe differs from sampling tick");
  AST_SAMPLE_SRC: assert property (disable iff (!RST_N) SAMPLING_CLOCK |-> $past(ANALOG_CLOCK))
    else $error("sampling tick without analog tick");
  AST_RATE_SRC: assert property (disable iff (!RST_N) OUTPUT_RATE_CLOCK |-> SAMPLING_CLOCK)
    else $error("rate tick off sampling tick");
  AST_RDY_START: assert property (disable iff (!RST_N) $fell(RESULT_READY_N) |-> OUTPUT_RATE_CLOCK)
    else $error("ready pulse without rate tick");
  AST_RDY_WIDTH: assert property (disable iff (!RST_N) $fell(RESULT_READY_N) |-> !RESULT_READY_N [*2])
    else $error("ready pulse too short");
endmodule // acdr_monitor
bind acdr_top acdr_monitor i_mon (.REF_CLK(REF_CLK), .RST_N(RST_N), .SERIAL_EN(SERIAL_EN),
  .INPUT_CLK_EN(INPUT_CLK_EN), .CORE_CLK_EN(CORE_CLK_EN), .ANALOG_CLOCK(ANALOG_CLOCK),
  .SAMPLING_CLOCK(SAMPLING_CLOCK), .OUTPUT_RATE_CLOCK(OUTPUT_RATE_CLOCK),
  .SAMPLE_STROBE(SAMPLE_STROBE), .RESULT_READY_N(RESULT_READY_N));
`default_nettype wire

// ===== acdr_clk_src.sv
// Oscillator and external clock source model
`timescale 1ns/1ps
`default_nettype none
module acdr_clk_src (
  output logic osc_in_pin, // Crystal level
  output logic ext_clk_in  // External clock level
);
  initial begin
    osc_in_pin = 1'b0;
    #13;
    forever #400 osc_in_pin = ~osc_in_pin;
  end
  assign ext_clk_in = ~osc_in_pin;
endmodule // acdr_clk_src
`default_nettype wire

// ===== test_adc_clock_divider_and_reset.sv
// Testbench for the converter clock divider and reset block
`timescale 1ns/1ps
`default_nettype none
module test_adc_clock_divider_and_reset;
  logic       clk, rst_n, xsel, load_p, sel_n;
  logic [1:0] pre;
  logic [2:0] osr;
  wire logic  osc, ext, mclk, ser_en, in_en, core_en, aclk, sclk, rclk, strobe, rdy_n;
  int         errors, total_checks;
  acdr_clk_src i_src (.osc_in_pin(osc), .ext_clk_in(ext));
  acdr_top i_dut (.REF_CLK(clk), .RST_N(rst_n), .OSC_IN_PIN(osc), .EXT_CLK_IN(ext),
    .EXT_CLOCK_SEL(xsel), .PRESCALE_SEL(pre), .OVERSAMPLE_SEL(osr), .CFG_LOAD(load_p),
    .SERIAL_SEL_N(sel_n), .MASTER_CLK_OUT(mclk), .SERIAL_EN(ser_en), .INPUT_CLK_EN(in_en),
    .CORE_CLK_EN(core_en), .ANALOG_CLOCK(aclk), .SAMPLING_CLOCK(sclk),
    .OUTPUT_RATE_CLOCK(rclk), .SAMPLE_STROBE(strobe), .RESULT_READY_N(rdy_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic load(input logic [1:0] p, input logic [2:0] o, input logic s);
    @(posedge clk);
    {pre, osr, xsel, load_p} <= {p, o, s, 1'b1};
    @(posedge clk);
    load_p <= 1'b0;
  endtask
  // One full result period, counted between rate ticks
  task automatic t_rates(input int p, input int r);
    int n = 0, ns = 0, lo = 0, na = 0, nst = 0;
    @(negedge clk iff rclk === 1'b1);
    do begin
      @(negedge clk);
      n++;
      ns += (sclk === 1'b1);
      lo += (rdy_n === 1'b0);
      na += (aclk === 1'b1);
      nst += (strobe === 1'b1);
    end while (rclk !== 1'b1);
    check(n == 4 * p * r, "result period");
    check(ns == r, "samples per result");
    check(lo == 2 * p, "ready low width");
    check(na == 4 * r, "analog ticks per result");
    check(nst == r, "sample strobes per result");
  endtask
  task automatic t_reset;
    int n = 5;
    @(posedge clk);
    {rst_n, sel_n, load_p, pre, osr} <= {1'b0, 1'b0, 1'b1, 2'h3, 3'h0};
    repeat (6) @(negedge clk);
    check(rdy_n === 1'b1 && {sclk, rclk, aclk} === 3'h0, "outputs in reset");
    check({ser_en, core_en, in_en} === 3'h1, "enables in reset");
    @(posedge clk);
    {rst_n, load_p} <= 2'h2;
    repeat (5) @(negedge clk);
    check({ser_en, core_en} === 2'h3, "enables after release");
    while (rclk !== 1'b1) begin
      @(negedge clk);
      n++;
    end
    check(n == 4 * 256 + 1, "first result after release");
    t_rates(1, 256);
  endtask
  task automatic t_sel(input logic s);
    load(2'h0, 3'h0, s);
    @(posedge osc);
    repeat (5) @(negedge clk);
    check(mclk === (s ? ext : osc), "selected master clock");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #4500000;
    errors++;
    report_and_stop;
  end
  initial begin
    {errors, total_checks} = '0;
    {rst_n, xsel, load_p, sel_n, pre, osr} = 9'h08;
    t_reset;
    for (int i = 0; i < 4; i++) begin
      load(i[1:0], 3'h0, 1'b0);
      t_rates(1 << i, 32);
    end
    for (int i = 1; i < 8; i++) begin
      load(2'h0, i[2:0], 1'b0);
      t_rates(1, 32 << i);
    end
    t_sel(1'b0);
    t_sel(1'b1);
    t_reset;
    report_and_stop;
  end
endmodule // test_adc_clock_divider_and_reset
`default_nettype wire
